// >>> rtl/iocu_decode.sv
// instruction field decoder with channel computation
`timescale 1ns/1ps
module iocu_decode
    import iocu_pkg::*;
(
    input  wire logic [35:0] instr,
    input  wire logic [3:0]  chan_sel,
    output logic             is_io,
    output logic [9:0]       func_code,
    output logic [3:0]       sub_code,
    output logic [3:0]       a_desig,
    output logic [3:0]       chan,
    output logic [15:0]      u_addr
);
    always_comb
    begin
        sub_code  = instr[SUB_HI:SUB_LO];
        a_desig   = instr[CH_HI:CH_LO];
        u_addr    = instr[U_HI:U_LO];
        func_code = {instr[FN_HI:FN_LO], instr[SUB_HI:SUB_LO]};
        is_io     = (func_code[9:4] == FN_IO);
        chan      = a_desig | chan_sel;
    end
endmodule : iocu_decode

// >>> rtl/iocu_pkg.sv
// package: constants for the io channel command unit
package iocu_pkg;
    localparam int          CHAN_COUNT   = 16;
    localparam logic [5:0]  FN_IO        = 6'h3_D;  // 75 octal
    localparam logic [3:0]  SUB_LOAD_IN      = 4'h0;
    localparam logic [3:0]  SUB_LOAD_IN_MON  = 4'h1;
    localparam logic [3:0]  SUB_DISC_OUT     = 4'h7;
    localparam logic [3:0]  SUB_LOAD_OUT     = 4'h4;
    localparam logic [3:0]  SUB_LOAD_OUT_MON = 4'h5;
    localparam logic [3:0]  SUB_LOAD_FN      = 4'h8;    // 10 octal
    localparam logic [3:0]  SUB_LOAD_FN_MON  = 4'h9;    // 11 octal
    localparam logic [3:0]  SUB_ALLOW_EXT    = 4'hC;    // 14 octal
    localparam logic [3:0]  SUB_PREVENT_EXT  = 4'hD;    // 15 octal
    localparam logic [3:0]  SUB_LOAD_SEL     = 4'hE;    // 16 octal
    localparam int          FN_HI        = 35;
    localparam int          FN_LO        = 30;
    localparam int          SUB_HI       = 29;
    localparam int          SUB_LO       = 26;
    localparam int          CH_HI        = 25;
    localparam int          CH_LO        = 22;
    localparam int          U_HI         = 15;
    localparam int          U_LO         = 0;
    localparam logic [5:0]  IN_ACW_BASE  = 6'h2_0;  // 40 octal
    localparam logic [5:0]  OUT_ACW_BASE = 6'h3_0;  // 60 octal
    localparam logic [4:0]  ADR_CTRL     = 5'h0_0;
    localparam logic [4:0]  ADR_STATUS   = 5'h0_4;
    localparam logic [4:0]  ADR_MASK     = 5'h0_8;
    localparam logic [4:0]  ADR_MODES    = 5'h0_C;
    localparam logic [4:0]  ADR_CSEL     = 5'h1_0;
    localparam logic [1:0]  MODE_IDLE    = 2'h0;
    localparam logic [1:0]  MODE_FUNC    = 2'h1;
    localparam logic [1:0]  MODE_IN      = 2'h2;
    localparam logic [1:0]  MODE_OUT     = 2'h3;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
endpackage : iocu_pkg

// >>> rtl/iocu_top.sv
// io channel command unit: executes 75-group channel instructions
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module iocu_top
    import iocu_pkg::*;
#(
    parameter int NCH = CHAN_COUNT
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             instr_valid,
    input  wire logic [35:0]      instr,
    input  wire logic [35:0]      operand,
    input  wire logic [NCH-1:0]   xfer_done,
    input  wire logic [NCH-1:0]   end_of_tape,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [4:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  instr_ack,
    output logic                  cr_we,
    output logic [5:0]            cr_addr,
    output logic [35:0]           cr_wdata,
    output logic [NCH-1:0]        chan_start,
    output logic [1:0]            start_mode,
    output logic [NCH-1:0]        chan_stop,
    output logic                  ext_irq,
    output logic [3:0]            ext_irq_chan,
    output logic                  irq
);
    logic        is_io;
    logic [9:0]  func_code;
    logic [3:0]  sub_code;
    logic [3:0]  a_desig;
    logic [3:0]  chan;

    // unit-wide and per-channel state and control
    logic [3:0]     chan_sel, next_chan_sel;
    logic           ext_en, next_ext_en;
    logic [NCH-1:0] mon, next_mon;
    logic [NCH-1:0] out_act, next_out_act;
    logic [NCH-1:0] func_act, next_func_act;
    logic           held, next_held;
    logic [3:0]     held_chan, next_held_chan;
    logic [NCH-1:0] status, next_status;
    logic [NCH-1:0] mask, next_mask;
    logic           next_instr_ack, next_cr_we;
    logic [5:0]     next_cr_addr;
    logic [35:0]    next_cr_wdata;
    logic [NCH-1:0] next_chan_start, next_chan_stop;
    logic [1:0]     next_start_mode;
    logic           next_ext_irq;
    logic [3:0]     next_ext_irq_chan;
    logic           next_irq, next_ack;
    logic [31:0]    next_dat;

    iocu_decode u_dec (
        .instr     (instr),
        .chan_sel  (chan_sel),
        .is_io     (is_io),
        .func_code (func_code),
        .sub_code  (sub_code),
        .a_desig   (a_desig),
        .chan      (chan),
        .u_addr    ()
    );

    function automatic logic [NCH-1:0] onehot(input logic [3:0] c);
        logic [NCH-1:0] v;
        v    = '0;
        v[c] = 1'b1;
        return v;
    endfunction : onehot

    function automatic logic [3:0] lowest(input logic [NCH-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NCH - 1; i >= 0; i--)
            if (v[i])
                r = 4'(i);
        return r;
    endfunction : lowest

    logic           take;
    logic           bus_req;
    logic [NCH-1:0] active;
    logic [NCH-1:0] finish;
    logic [NCH-1:0] stat_set;

    always_comb
    begin
        take    = instr_valid && !instr_ack && is_io;
        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        active  = out_act | func_act;
        finish  = active & (xfer_done | end_of_tape);
        stat_set = finish & mon;
        next_chan_sel   = chan_sel;
        next_ext_en     = ext_en;
        next_mon        = mon & ~finish;
        next_out_act    = out_act & ~finish;
        next_func_act   = func_act & ~finish;
        next_instr_ack  = take;
        next_cr_we      = 1'b0;
        next_cr_addr    = cr_addr;
        next_cr_wdata   = cr_wdata;
        next_chan_start = '0;
        next_chan_stop  = '0;
        next_start_mode = start_mode;
        next_held       = held;
        next_held_chan  = held_chan;
        next_ext_irq    = 1'b0;
        next_ext_irq_chan = ext_irq_chan;
        if (take)
        begin
            unique case (sub_code)
                SUB_LOAD_IN, SUB_LOAD_IN_MON:
                begin
                    next_cr_we      = 1'b1;
                    next_cr_addr    = IN_ACW_BASE + {2'b00, chan};
                    next_cr_wdata   = operand;
                    next_chan_start = onehot(chan);
                    next_start_mode = MODE_FUNC;
                    next_func_act   = next_func_act | onehot(chan);
                    if (sub_code == SUB_LOAD_IN_MON)
                        next_mon = next_mon | onehot(chan);
                end
                SUB_LOAD_OUT, SUB_LOAD_OUT_MON:
                begin
                    next_cr_we      = 1'b1;
                    next_cr_addr    = OUT_ACW_BASE + {2'b00, chan};
                    next_cr_wdata   = operand;
                    next_chan_start = onehot(chan);
                    next_start_mode = MODE_OUT;
                    next_out_act    = next_out_act | onehot(chan);
                    if (sub_code == SUB_LOAD_OUT_MON)
                        next_mon = next_mon | onehot(chan);
                    else
                        next_mon = next_mon & ~onehot(chan);
                end
                SUB_LOAD_FN, SUB_LOAD_FN_MON:
                begin
                    next_cr_we      = 1'b1;
                    next_cr_addr    = OUT_ACW_BASE + {2'b00, chan};
                    next_cr_wdata   = operand;
                    next_chan_start = onehot(chan);
                    next_start_mode = MODE_FUNC;
                    next_func_act   = next_func_act | onehot(chan);
                    if (sub_code == SUB_LOAD_FN_MON)
                        next_mon = next_mon | onehot(chan);
                end
                SUB_DISC_OUT:
                begin
                    next_chan_stop = onehot(a_desig);
                    next_out_act   = next_out_act & ~onehot(a_desig);
                    next_func_act  = next_func_act & ~onehot(a_desig);
                    next_mon       = next_mon & ~onehot(a_desig);
                end
                SUB_ALLOW_EXT:   next_ext_en = 1'b1;
                SUB_PREVENT_EXT: next_ext_en = 1'b0;
                SUB_LOAD_SEL:    next_chan_sel = operand[3:0];
                default:  next_instr_ack = take;
            endcase
        end
        // completion interrupts enter the holding stage only while enabled
        if (held)
        begin
            next_ext_irq      = 1'b1;
            next_ext_irq_chan = held_chan;
            next_held         = 1'b0;
        end
        if (finish != '0 && ext_en)
        begin
            next_held      = 1'b1;
            next_held_chan = lowest(finish);
        end
        next_status = status | stat_set;
        next_mask   = mask;
        next_ack    = bus_req;
        next_dat    = ZERO_WORD;
        if (bus_req)
        begin
            unique case (wb_adr_i)
                ADR_CTRL:
                    next_dat = {27'h000_0000, ext_en, chan_sel};
                ADR_STATUS:
                begin
                    next_dat = {{(32-NCH){1'b0}}, status};
                    if (!wb_we_i)
                        next_status = stat_set;
                end
                ADR_MASK:
                    next_dat = {{(32-NCH){1'b0}}, mask};
                ADR_MODES:
                    next_dat = {{(32-NCH){1'b0}}, active};
                ADR_CSEL:
                    next_dat = {28'h000_0000, chan_sel};
                default:
                    next_dat = ZERO_WORD;
            endcase
            if (wb_we_i)
            begin
                if (wb_adr_i == ADR_MASK && wb_sel_i[0])
                    next_mask[7:0] = wb_dat_i[7:0];
                if (wb_adr_i == ADR_MASK && wb_sel_i[1])
                    next_mask[NCH-1:8] = wb_dat_i[NCH-1:8];
                if (wb_adr_i == ADR_CTRL && wb_sel_i[0] && !take)
                begin
                    next_chan_sel = wb_dat_i[3:0];
                    next_ext_en   = wb_dat_i[4];
                end
            end
        end
        next_irq = (next_status & next_mask) != '0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chan_sel     <= 4'h0;
            ext_en       <= 1'b0;
            mon          <= '0;
            out_act      <= '0;
            func_act     <= '0;
            held         <= 1'b0;
            held_chan    <= 4'h0;
            status       <= '0;
            mask         <= '0;
            instr_ack    <= 1'b0;
            cr_we        <= 1'b0;
            cr_addr      <= 6'h0_0;
            cr_wdata     <= 36'h0_0000_0000;
            chan_start   <= '0;
            chan_stop    <= '0;
            start_mode   <= MODE_IDLE;
            ext_irq      <= 1'b0;
            ext_irq_chan <= 4'h0;
            irq          <= 1'b0;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= ZERO_WORD;
        end
        else
        begin
            chan_sel     <= next_chan_sel;
            ext_en       <= next_ext_en;
            mon          <= next_mon;
            out_act      <= next_out_act;
            func_act     <= next_func_act;
            held         <= next_held;
            held_chan    <= next_held_chan;
            status       <= next_status;
            mask         <= next_mask;
            instr_ack    <= next_instr_ack;
            cr_we        <= next_cr_we;
            cr_addr      <= next_cr_addr;
            cr_wdata     <= next_cr_wdata;
            chan_start   <= next_chan_start;
            chan_stop    <= next_chan_stop;
            start_mode   <= next_start_mode;
            ext_irq      <= next_ext_irq;
            ext_irq_chan <= next_ext_irq_chan;
            irq          <= next_irq;
            wb_ack_o     <= next_ack;
            wb_dat_o     <= next_dat;
        end
    end

    a_input_load: assert property (@(posedge clk) disable iff (rst)
        take && (sub_code == SUB_LOAD_IN || sub_code == SUB_LOAD_IN_MON)
        |=> cr_we && cr_addr == IN_ACW_BASE + {2'b00, $past(chan)}
        && start_mode == MODE_FUNC && chan_start == onehot($past(chan)))
        else $error("input load did not write input word or start");
    a_output_load: assert property (@(posedge clk) disable iff (rst)
        take && (sub_code == SUB_LOAD_OUT || sub_code == SUB_LOAD_OUT_MON)
        |=> cr_we && cr_addr == OUT_ACW_BASE + {2'b00, $past(chan)}
        && start_mode == MODE_OUT && chan_start == onehot($past(chan)))
        else $error("output load wrong address or mode");
    a_func_load: assert property (@(posedge clk) disable iff (rst)
        take && (sub_code == SUB_LOAD_FN || sub_code == SUB_LOAD_FN_MON)
        |=> cr_we && cr_addr == OUT_ACW_BASE + {2'b00, $past(chan)}
        && start_mode == MODE_FUNC && cr_wdata == $past(operand))
        else $error("function load wrong");
    a_disconnect: assert property (@(posedge clk) disable iff (rst)
        take && sub_code == SUB_DISC_OUT
        |=> chan_stop == onehot($past(a_desig))
        ##1 (!out_act[$past(a_desig, 2)] && !func_act[$past(a_desig, 2)]))
        else $error("disconnect did not stop channel");
    a_enable_ext: assert property (@(posedge clk) disable iff (rst)
        take && sub_code == SUB_ALLOW_EXT |=> ext_en)
        else $error("external interrupts not enabled");
    a_disable_ext: assert property (@(posedge clk) disable iff (rst)
        take && sub_code == SUB_PREVENT_EXT && !held |=> !ext_en ##1 !held)
        else $error("external interrupt entered after disable");
    a_held_delivered: assert property (@(posedge clk) disable iff (rst)
        held |=> ext_irq && ext_irq_chan == $past(held_chan))
        else $error("held external interrupt not delivered");
    a_monitor_irq: assert property (@(posedge clk) disable iff (rst)
        (finish & mon) != '0 |=> (status & $past(finish & mon)) != '0)
        else $error("monitor completion not recorded");
    a_chan_compute: assert property (@(posedge clk) disable iff (rst)
        chan == (instr[CH_HI:CH_LO] | chan_sel)
        && func_code == {instr[FN_HI:FN_LO], instr[SUB_HI:SUB_LO]}
        && is_io == (instr[FN_HI:FN_LO] == FN_IO))
        else $error("channel or function code mis-formed");
endmodule : iocu_top

// >>> sim/iocu_periph_model.sv
// model of the peripheral subsystems on the channels
`timescale 1ns/1ps
module iocu_periph_model
    import iocu_pkg::*;
#(
    parameter int NCH = CHAN_COUNT
)
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic [NCH-1:0] chan_start,
    input  wire logic [NCH-1:0] chan_stop,
    input  wire logic           slow,
    input  wire logic           eot,
    output logic [NCH-1:0]      xfer_done,
    output logic [NCH-1:0]      end_of_tape
);
    int cnt [NCH];
    always @(posedge clk or posedge rst)
    begin
        xfer_done   <= '0;
        end_of_tape <= '0;
        for (int i = 0; i < NCH; i++)
        begin
            if (rst)
                cnt[i] <= 0;
            else if (chan_start[i])  // transfer runs under access word
                cnt[i] <= slow ? 40 : 3 + i % 3;
            else if (chan_stop[i])
                cnt[i] <= 0;
            else if (cnt[i] == 1)  // count zero or tape end
            begin
                xfer_done[i]   <= !eot;
                end_of_tape[i] <= eot;
                cnt[i]         <= 0;
            end
            else if (cnt[i] > 1)
                cnt[i] <= cnt[i] - 1;
        end
    end
endmodule : iocu_periph_model

// >>> sim/tb.sv
// self-checking testbench for the io channel command unit
`timescale 1ns/1ps
module tb;
    import iocu_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic [35:0] instr = '0, operand = '0, op, got_data;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0]  wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = '0, ext_irq_chan, last_ch, sub, a, sel_val, ch;
    logic        slow = 1'b0, eot = 1'b0, wb_ack_o, instr_ack, cr_we;
    logic        ext_irq, irq, got_we, mon;
    logic [5:0]  cr_addr, got_addr;
    logic [15:0] xfer_done, end_of_tape, chan_start, chan_stop, mask;
    logic [15:0] got_start, got_stop;
    logic [1:0]  start_mode, got_mode;
    int          seed = 32'hc0d1_dc41;
    int          mismatches = 0, n_compared = 0, n_ext = 0, t, n0;
    logic [3:0]  subs [6] = '{SUB_LOAD_IN, SUB_LOAD_IN_MON, SUB_LOAD_FN,
                              SUB_LOAD_FN_MON, SUB_LOAD_OUT,
                              SUB_LOAD_OUT_MON};

    always #12.5 clk = ~clk;

    iocu_top iocu_top_inst (.clk, .rst, .instr_valid, .instr, .operand,
        .xfer_done, .end_of_tape, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
        .instr_ack, .cr_we, .cr_addr, .cr_wdata(got_data), .chan_start,
        .start_mode, .chan_stop, .ext_irq, .ext_irq_chan, .irq);
    iocu_periph_model iocu_periph_model_inst (.clk, .rst, .chan_start,
        .chan_stop, .slow, .eot, .xfer_done, .end_of_tape);

    always @(posedge clk)
        if (ext_irq === 1'b1)
        begin
            n_ext   <= n_ext + 1;
            last_ch <= ext_irq_chan;
        end

    task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    function automatic logic [5:0] exp_addr(logic [3:0] s, logic [3:0] c);
        return ((s == SUB_LOAD_IN || s == SUB_LOAD_IN_MON) ? IN_ACW_BASE
                : OUT_ACW_BASE) + {2'b00, c};
    endfunction : exp_addr

    // one instruction, outputs taken at the acknowledging edge
    task automatic do_instr(logic [3:0] s, logic [3:0] ad, logic [35:0] u);
        t = 0;
        instr_valid <= 1'b1;
        instr       <= {FN_IO, s, ad, 22'h00_0000};
        operand     <= u;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (instr_ack !== 1'b1 && t < 50);
        if (t >= 50)
            mismatches++;
        {got_we, got_addr, got_start, got_mode, got_stop} =
            {cr_we, cr_addr, chan_start, start_mode, chan_stop};
        instr_valid <= 1'b0;
        @(posedge clk);
    endtask : do_instr

    task automatic wb(logic we, logic [4:0] adr, logic [31:0] d);
        t = 0;
        {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h3_F;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (wb_ack_o !== 1'b1 && t < 50);
        if (t >= 50)
            mismatches++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask : wb

    task automatic wait_ext(int base);
        t = 0;
        while (n_ext == base && t < 200)
        begin
            @(posedge clk);
            t++;
        end
    endtask : wait_ext

    // a hang is cut after 20000 clock cycles, about twenty times the expected run
    initial
    begin
        #(25 * 20000);
        mismatches++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b1, 5'h1_4, 32'hffff_ffff);
        wb(1'b0, 5'h1_4, 32'h0000_0000);
        check("unmapped", rd, 0);
        instr_valid <= 1'b1;
        instr       <= {6'h2_0, SUB_LOAD_IN, 4'h1, 22'h00_0000};
        repeat (6)
        begin
            @(posedge clk);
            check("foreign ack", instr_ack, 0);
        end
        instr_valid <= 1'b0;
        @(posedge clk);
        $display("test refusals done");
        for (int k = 0; k < 18; k++)
        begin
            sub  = subs[k % 6];  // input, function, output
            if (k % 6 == 0)
            begin
                a       = 4'($random(seed));
                sel_val = (k < 6) ? 4'h0 : 4'($random(seed));
            end
            mask = 16'($random(seed));
            ch   = a | sel_val;
            op   = {4'($random(seed)), 32'($random(seed))};
            slow <= ($random(seed) % 4) == 0;
            eot  <= 1'($random(seed));
            mon  = (sub == SUB_LOAD_IN_MON || sub == SUB_LOAD_OUT_MON
                    || sub == SUB_LOAD_FN_MON);
            wb(1'b1, ADR_CTRL, 32'h0000_0010);
            wb(1'b1, ADR_MASK, {16'h0000, mask});
            do_instr(SUB_LOAD_SEL, 4'h0, {32'h0000_0000, sel_val});
            wb(1'b0, ADR_CSEL, 32'h0000_0000);
            check("csel", rd, {28'h000_0000, sel_val});
            n0 = n_ext;
            do_instr(sub, a, op);
            check("cr_we", got_we, 1);
            check("cr_addr", got_addr, exp_addr(sub, ch));
            check("cr_wdata", got_data, op);
            check("start", got_start, 16'h0001 << ch);
            check("mode", got_mode,
                  (sub == SUB_LOAD_OUT || sub == SUB_LOAD_OUT_MON)
                  ? MODE_OUT : MODE_FUNC);
            wait_ext(n0);
            check("ext count", 36'(n_ext - n0), 1);
            check("ext chan", last_ch, ch);
            check("irq", irq, mon & mask[ch]);
            wb(1'b0, ADR_STATUS, 32'h0000_0000);
            check("status", rd, mon ? 32'h1 << ch : 0);
            check("irq cleared", irq, 0);
        end
        $display("test channel loads done");
        slow <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, ADR_CTRL, 32'h0000_0015);
            if (k)
                do_instr(SUB_LOAD_IN_MON, 4'h2, 36'h0_0000_0000);
            do_instr(k ? SUB_LOAD_FN_MON : SUB_LOAD_OUT_MON, 4'h2,
                     36'h0_0000_0000);
            wb(1'b0, ADR_MODES, 32'h0000_0000);
            check("active", rd, 32'h0000_0080);
            wb(1'b1, ADR_CTRL, 32'h0000_0018);
            n0 = n_ext;
            do_instr(SUB_DISC_OUT, 4'h7, 36'h0_0000_0000);
            check("stop", got_stop, 16'h0080);
            repeat (60) @(posedge clk);
            check("no ext", 36'(n_ext - n0), 0);
            wb(1'b0, ADR_MODES, 32'h0000_0000);
            check("inactive", rd, 0);
            wb(1'b0, ADR_STATUS, 32'h0000_0000);
            check("status", rd, 0);
        end
        $display("test disconnect done");
        {slow, eot} <= 2'b00;
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        do_instr(SUB_ALLOW_EXT, 4'h0, 36'h0_0000_0000);
        wb(1'b0, ADR_CTRL, 32'h0000_0000);
        check("ctrl", rd, 32'h0000_0010);
        do_instr(SUB_LOAD_IN_MON, 4'h3, 36'h0_0000_0000);
        n0 = n_ext;
        t  = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (xfer_done[3] !== 1'b1 && t < 100);
        do_instr(SUB_PREVENT_EXT, 4'h0, 36'h0_0000_0000);
        repeat (4) @(posedge clk);
        check("held ext", 36'(n_ext - n0), 1);
        wb(1'b0, ADR_CTRL, 32'h0000_0000);
        check("ctrl", rd, 0);
        do_instr(SUB_PREVENT_EXT, 4'h0, 36'h0_0000_0000);
        do_instr(SUB_LOAD_IN_MON, 4'h4, 36'h0_0000_0000);
        repeat (20) @(posedge clk);
        check("blocked ext", 36'(n_ext - n0), 1);
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
        check("status", rd, 32'h0000_0018);
        $display("test interrupt gate done");
        test_done();
    end
endmodule : tb
